// >>> core/integ_engine.v
`default_nettype none
`include "light_sensor_consts.vh"
module integ_engine (
	input wire clk, // system clock
	input wire rst_n, // async reset, active low
	input wire osc_tick, // one-cycle pulse per oscillator cycle
	input wire conv_pulse, // one-cycle pulse per charge-balance packet
	input wire exec_stb, // execute the command below
	input wire [7:0] cmd, // command to execute
	output reg power_down, // converter powered down
	output wire channel_dark, // analog front end integrates dark diode
	output wire busy, // integration running
	output reg [15:0] sensor_result_value, // latched sensor reading
	output reg [15:0] integration_count_value // latched oscillator count
);
	reg run_r;
	reg ext_r;
	reg [1:0] chan_r;
	reg phase_r;
	reg [15:0] osc_cnt_r;
	reg [15:0] per_cnt_r;
	reg [15:0] acc_r;
	wire [1:0] cmd_chan = cmd[`CHAN_LSB+1:`CHAN_LSB];
	wire is_int = (cmd == `CMD_INT_MAIN) || (cmd == `CMD_INT_DARK) || (cmd == `CMD_INT_DIFF);
	wire is_ext = (cmd == `CMD_EXT_MAIN) || (cmd == `CMD_EXT_DARK) || (cmd == `CMD_EXT_DIFF);
	// in external difference mode the front end chops between diodes per oscillator cycle
	assign channel_dark = (chan_r == `CHAN_DARK) ||
		((chan_r == `CHAN_DIFF) && (ext_r ? osc_cnt_r[0] : ~phase_r));
	assign busy = run_r;
	wire subtract = (chan_r == `CHAN_DIFF) && channel_dark;
	wire [15:0] acc_nxt = !conv_pulse ? acc_r :
		subtract ? acc_r - 16'h0001 : acc_r + 16'h0001;
	wire [15:0] osc_nxt = osc_tick ? osc_cnt_r + 16'h0001 : osc_cnt_r;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			run_r <= 1'b0;
			ext_r <= 1'b0;
			chan_r <= `CHAN_MAIN;
			phase_r <= 1'b0;
			osc_cnt_r <= 16'h0000;
			per_cnt_r <= 16'h0000;
			acc_r <= 16'h0000;
			power_down <= 1'b0;
			sensor_result_value <= 16'h0000;
			integration_count_value <= 16'h0000;
		end else if (exec_stb) begin
			power_down <= 1'b0;
			if (cmd == `CMD_PWRDN) begin
				power_down <= 1'b1;
				run_r <= 1'b0;
			end else if (cmd == `CMD_RESET) begin
				acc_r <= 16'h0000;
				osc_cnt_r <= 16'h0000;
				per_cnt_r <= 16'h0000;
				run_r <= 1'b0;
			end else if (is_int || is_ext) begin
				if (is_ext && ext_r && run_r) begin
					sensor_result_value <= acc_nxt;
					integration_count_value <= osc_nxt;
				end
				acc_r <= 16'h0000;
				osc_cnt_r <= 16'h0000;
				per_cnt_r <= 16'h0000;
				phase_r <= (cmd_chan != `CHAN_DIFF);
				run_r <= 1'b1;
				ext_r <= is_ext;
				chan_r <= cmd_chan;
			end
		end else if (run_r) begin
			acc_r <= acc_nxt;
			osc_cnt_r <= osc_nxt;
			if (osc_tick && !ext_r) begin
				if (per_cnt_r == `INT_PERIOD_LAST) begin
					per_cnt_r <= 16'h0000;
					if (!phase_r) begin
						phase_r <= 1'b1;
					end else begin
						sensor_result_value <= acc_nxt;
						integration_count_value <= osc_nxt;
						run_r <= 1'b0;
					end
				end else begin
					per_cnt_r <= per_cnt_r + 16'h0001;
				end
			end
		end
	end
endmodule
`default_nettype wire

// >>> core/light_sensor_consts.vh
`ifndef LIGHT_SENSOR_CONSTS_VH
`define LIGHT_SENSOR_CONSTS_VH
// target address: fixed upper nibble, low three bits from the select pins
`define ADDR_UPPER 4'h8
// command codes
`define CMD_PWRDN 8'h8C
`define CMD_RESET 8'h0C
`define CMD_INT_MAIN 8'h00
`define CMD_INT_DARK 8'h04
`define CMD_INT_DIFF 8'h08
`define CMD_EXT_MAIN 8'h30
`define CMD_EXT_DARK 8'h34
`define CMD_EXT_DIFF 8'h38
`define CMD_TEST_BIT 7
`define CMD_RESET_VAL 8'h0C
// channel field of a conversion command
`define CHAN_LSB 2
`define CHAN_MAIN 2'h0
`define CHAN_DARK 2'h1
`define CHAN_DIFF 2'h2
// result byte order on a read
`define OFS_RES_LO 3'h0
`define OFS_RES_HI 3'h1
`define OFS_CNT_LO 3'h2
`define OFS_CNT_HI 3'h3
`define RD_BYTES_INT 3'h2
`define RD_BYTES_EXT 3'h4
// oscillator cycles in one self-timed integration period (32768)
`define INT_PERIOD_LAST 16'h7FFF
`endif

// >>> core/light_sensor_i2c_command_port.v
`default_nettype none
`include "light_sensor_consts.vh"
// Overview of operation
// - one 8-bit command register, behaviour fixed until it is rewritten
// - address is binary 1000 plus three select pins
// - each written data byte replaces the command and takes effect at once
// - no sub-address; no byte is ever taken as a register index
// - command starts a conversion; results update only when it completes
// - reads during a conversion return the previous stored result
// - address-only write re-executes the stored command
// - read order: result low, result high, count low, count high
// - self-timed modes offer only two bytes, then the device stops sending
// - 8C powers down the converter; any other command wakes it
// - 0C clears result counter and oscillator count
// - 00/04/08 self-timed main, dark, or main minus dark
// - self-timed conversions are timed internally, nominally 110 ms
// - 30/34/38 externally timed with the same channels
// - each external command latches results if an external conversion is running, and restarts; spaced 1-100 ms
// - byte with top bit set is a loopback read back on reads
// - oscillator drives a 16-bit counter captured at integration end
// - counter bytes offered only in externally timed modes
// - receiver pulls data low during the acknowledge clock
// - self-timed difference mode integrates dark first, then main, doubling the time
// - a self-timed period is exactly 32768 oscillator cycles
module light_sensor_i2c_command_port (
	input wire clk, // 125 MHz system clock
	input wire rst_n, // async reset, active low
	input wire scl_in, // bus clock pin level
	input wire sda_in, // bus data pin level
	output wire sda_out, // data pin drive value, always low
	output reg sda_oe_n, // data pin enable, low while pulling low
	input wire addr_select_bit0, // address pin 0
	input wire addr_select_bit1, // address pin 1
	input wire addr_select_bit2, // address pin 2
	input wire osc_in, // internal oscillator clock
	input wire conv_pulse_in, // charge-balance converter pulses
	output wire adc_power_down, // converter powered down
	output wire photodiode_dark_sel, // front end integrates dark diode
	output wire conversion_busy, // integration running
	output reg [7:0] command_value // current command register
);
	localparam ST_IDLE = 3'h0;
	localparam ST_ADDR = 3'h1;
	localparam ST_AACK = 3'h2;
	localparam ST_WDATA = 3'h3;
	localparam ST_WACK = 3'h4;
	localparam ST_RDATA = 3'h5;
	localparam ST_RACK = 3'h6;
	localparam NSYNC = 7;

	wire [NSYNC-1:0] raw_in = {conv_pulse_in, osc_in, addr_select_bit2, addr_select_bit1,
		addr_select_bit0, sda_in, scl_in};
	reg [NSYNC-1:0] meta_r;
	reg [NSYNC-1:0] sync_r;
	reg [NSYNC-1:0] prev_r;
	genvar g;
	generate
		for (g = 0; g < NSYNC; g = g + 1) begin : g_sync
			always @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					meta_r[g] <= 1'b1;
					sync_r[g] <= 1'b1;
					prev_r[g] <= 1'b1;
				end else begin
					meta_r[g] <= raw_in[g];
					sync_r[g] <= meta_r[g];
					prev_r[g] <= sync_r[g];
				end
			end
		end
	endgenerate

	wire scl = sync_r[0];
	wire sda = sync_r[1];
	wire [2:0] addr_pins = sync_r[4:2];
	wire scl_rise = scl & ~prev_r[0];
	wire scl_fall = ~scl & prev_r[0];
	wire start_cond = scl & prev_r[0] & ~sda & prev_r[1];
	wire stop_cond = scl & prev_r[0] & sda & ~prev_r[1];
	wire osc_tick = sync_r[5] & ~prev_r[5];
	wire conv_tick = sync_r[6] & ~prev_r[6];
	wire [6:0] my_addr = {`ADDR_UPPER, addr_pins};

	reg [2:0] state_r;
	reg [3:0] bit_cnt_r;
	reg [7:0] shift_r;
	reg [7:0] tx_r;
	reg rw_r;
	reg hit_r;
	reg got_byte_r;
	reg master_ack_r;
	reg [2:0] byte_idx_r;
	reg exec_r;
	reg [15:0] snap_res_r;
	reg [15:0] snap_cnt_r;
	wire [15:0] sensor_result_value;
	wire [15:0] integration_count_value;

	assign sda_out = 1'b0;

	wire ext_mode = (command_value == `CMD_EXT_MAIN) || (command_value == `CMD_EXT_DARK) ||
		(command_value == `CMD_EXT_DIFF);
	wire loopback = command_value[`CMD_TEST_BIT];
	wire [2:0] avail = ext_mode ? `RD_BYTES_EXT : `RD_BYTES_INT;

	// result byte for a given position of the read burst
	function [7:0] rd_byte;
		input [2:0] idx;
		begin
			if (loopback) begin
				rd_byte = command_value;
			end else begin
				case (idx)
					`OFS_RES_LO: rd_byte = snap_res_r[7:0];
					`OFS_RES_HI: rd_byte = snap_res_r[15:8];
					`OFS_CNT_LO: rd_byte = snap_cnt_r[7:0];
					`OFS_CNT_HI: rd_byte = snap_cnt_r[15:8];
					default: rd_byte = 8'hFF;
				endcase
			end
		end
	endfunction

	wire [2:0] next_idx = byte_idx_r + 3'h1;
	wire [7:0] first_byte = rd_byte(`OFS_RES_LO);
	wire [7:0] next_byte = rd_byte(next_idx);

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= ST_IDLE;
			bit_cnt_r <= 4'h0;
			shift_r <= 8'h00;
			tx_r <= 8'h00;
			rw_r <= 1'b0;
			hit_r <= 1'b0;
			got_byte_r <= 1'b0;
			master_ack_r <= 1'b0;
			byte_idx_r <= 3'h0;
			exec_r <= 1'b0;
			sda_oe_n <= 1'b1;
			command_value <= `CMD_RESET_VAL;
			snap_res_r <= 16'h0000;
			snap_cnt_r <= 16'h0000;
		end else begin
			exec_r <= 1'b0;
			if (start_cond) begin
				state_r <= ST_ADDR;
				bit_cnt_r <= 4'h0;
				hit_r <= 1'b0;
				got_byte_r <= 1'b0;
				sda_oe_n <= 1'b1;
			end else if (stop_cond) begin
				if (hit_r && !rw_r && !got_byte_r) begin
					exec_r <= 1'b1;
				end
				hit_r <= 1'b0;
				state_r <= ST_IDLE;
				sda_oe_n <= 1'b1;
			end else if (scl_rise) begin
				case (state_r)
					ST_ADDR, ST_WDATA: begin
						shift_r <= {shift_r[6:0], sda};
						bit_cnt_r <= bit_cnt_r + 4'h1;
					end
					ST_RACK: master_ack_r <= ~sda;
					default: ;
				endcase
			end else if (scl_fall) begin
				case (state_r)
					ST_ADDR: begin
						if (bit_cnt_r == 4'h8) begin
							if (shift_r[7:1] == my_addr) begin
								hit_r <= 1'b1;
								rw_r <= shift_r[0];
								sda_oe_n <= 1'b0;
								state_r <= ST_AACK;
								snap_res_r <= sensor_result_value;
								snap_cnt_r <= integration_count_value;
							end else begin
								state_r <= ST_IDLE;
							end
						end
					end
					ST_AACK: begin
						bit_cnt_r <= 4'h0;
						if (rw_r) begin
							byte_idx_r <= `OFS_RES_LO;
							tx_r <= first_byte;
							sda_oe_n <= first_byte[7];
							bit_cnt_r <= 4'h1;
							state_r <= ST_RDATA;
						end else begin
							sda_oe_n <= 1'b1;
							state_r <= ST_WDATA;
						end
					end
					ST_WDATA: begin
						if (bit_cnt_r == 4'h8) begin
							command_value <= shift_r;
							exec_r <= 1'b1;
							got_byte_r <= 1'b1;
							sda_oe_n <= 1'b0;
							state_r <= ST_WACK;
						end
					end
					ST_WACK: begin
						sda_oe_n <= 1'b1;
						bit_cnt_r <= 4'h0;
						state_r <= ST_WDATA;
					end
					ST_RDATA: begin
						if (bit_cnt_r == 4'h8) begin
							sda_oe_n <= 1'b1;
							state_r <= ST_RACK;
						end else begin
							sda_oe_n <= tx_r[7 - bit_cnt_r[2:0]];
							bit_cnt_r <= bit_cnt_r + 4'h1;
						end
					end
					ST_RACK: begin
						if (master_ack_r && (next_idx < avail)) begin
							byte_idx_r <= next_idx;
							tx_r <= next_byte;
							sda_oe_n <= next_byte[7];
							bit_cnt_r <= 4'h1;
							state_r <= ST_RDATA;
						end else begin
							sda_oe_n <= 1'b1;
							state_r <= ST_IDLE;
						end
					end
					default: state_r <= ST_IDLE;
				endcase
			end
		end
	end

	integ_engine u_engine (
		.clk(clk),
		.rst_n(rst_n),
		.osc_tick(osc_tick),
		.conv_pulse(conv_tick),
		.exec_stb(exec_r),
		.cmd(command_value),
		.power_down(adc_power_down),
		.channel_dark(photodiode_dark_sel),
		.busy(conversion_busy),
		.sensor_result_value(sensor_result_value),
		.integration_count_value(integration_count_value)
	);
endmodule
`default_nettype wire

// >>> testbench/i2c_host_model.sv
`default_nettype none
module i2c_host_model (
	input wire logic clk, // system clock
	input wire logic sda, // resolved data line
	output logic scl, // bus clock
	output logic sda_rel // high releases data line
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		scl = 1'b1;
		sda_rel = 1'b1;
	end
	// quarter of a bit time, giving a 128 ns bus clock period
	task automatic q;
		repeat (4) @(negedge clk);
	endtask
	task automatic start;
		sda_rel = 1'b1;
		q;
		scl = 1'b1;
		q;
		sda_rel = 1'b0;
		q;
		scl = 1'b0;
		q;
	endtask
	task automatic stop;
		sda_rel = 1'b0;
		q;
		scl = 1'b1;
		q;
		sda_rel = 1'b1;
		q;
	endtask
	// data changes only while the clock is low
	task automatic bit_io(input logic b, output logic s);
		sda_rel = b;
		q;
		scl = 1'b1;
		q;
		s = sda;
		q;
		scl = 1'b0;
		q;
	endtask
	task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx, output logic ack);
		for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
		bit_io(ack_in, ack);
	endtask
endmodule
`default_nettype wire

// >>> testbench/light_sensor_i2c_command_port_tb.sv
`default_nettype none
module light_sensor_i2c_command_port_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic osc = 1'b0;
	logic conv = 1'b0;
	logic [2:0] asel = 3'h4;
	logic [7:0] rx;
	logic ack;
	int err_total = 0;
	int tests_run = 0;
	wire scl, host_rel, sda_oe_n, sda_out, pd, dark, busy;
	wire [7:0] cmd;
	wire sda = sda_oe_n & host_rel; // pull-up unless someone drives low
	always #4 clk = ~clk;
	i2c_host_model host (.clk(clk), .sda(sda), .scl(scl), .sda_rel(host_rel));
	light_sensor_i2c_command_port u_dut (.clk(clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
		.sda_oe_n(sda_oe_n), .addr_select_bit0(asel[0]), .addr_select_bit1(asel[1]), .addr_select_bit2(asel[2]),
		.osc_in(osc), .conv_pulse_in(conv), .adc_power_down(pd), .photodiode_dark_sel(dark),
		.conversion_busy(busy), .command_value(cmd));
	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic wr_cmd(input logic [7:0] d, input bit with_data);
		host.start;
		host.xfer({4'h8, asel, 1'b0}, 1'b1, rx, ack);
		chk("write addr ack", 16'h0, {15'h0, ack});
		if (with_data) begin
			host.xfer(d, 1'b1, rx, ack);
			chk("data ack", 16'h0, {15'h0, ack});
		end
		host.stop;
	endtask
	// reads n bytes, byte i expected in e[8i+7:8i], last one not acknowledged
	task automatic rd(input int n, input logic [31:0] e);
		host.start;
		host.xfer({4'h8, asel, 1'b1}, 1'b1, rx, ack);
		chk("read addr ack", 16'h0, {15'h0, ack});
		for (int i = 0; i < n; i++) begin
			host.xfer(8'hFF, i == n - 1, rx, ack);
			chk("read byte", {8'h0, e[8*i+:8]}, {8'h0, rx});
		end
		host.stop;
	endtask
	// oscillator bursts at 128 ns, one converter pulse every second cycle
	task automatic osc_run(input int n);
		for (int i = 0; i < n; i++) begin
			conv = i[0];
			osc = 1'b1;
			repeat (8) @(negedge clk);
			osc = 1'b0;
			conv = 1'b0;
			repeat (8) @(negedge clk);
		end
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	initial begin
		#400000;
		err_total++;
		wrap_up;
	end
	initial begin
		repeat (16) @(negedge clk);
		rst_n = 1'b1;
		repeat (4) @(negedge clk);
		chk("reset command", 16'h0C, {8'h0, cmd});
		chk("reset flags", 16'h0, {14'h0, pd, busy});
		rd(3, 32'h00FF_0000);
		host.start;
		host.xfer({4'h8, 3'h5, 1'b0}, 1'b1, rx, ack);
		chk("foreign addr ack", 16'h1, {15'h0, ack});
		host.stop;
		wr_cmd(8'h30, 1'b1);
		chk("ext busy", 16'h1, {15'h0, busy});
		osc_run(40);
		wr_cmd(8'h30, 1'b1);
		rd(4, 32'h0028_0014);
		osc_run(6);
		wr_cmd(8'h30, 1'b0);
		rd(4, 32'h0006_0003);
		wr_cmd(8'h00, 1'b1);
		chk("int busy", 16'h1, {15'h0, busy});
		rd(3, 32'h00FF_0003);
		rd(2, 32'h0000_0003);
		wr_cmd(8'h34, 1'b1);
		chk("dark select", 16'h1, {15'h0, dark});
		wr_cmd(8'h0C, 1'b1);
		chk("reset idle", 16'h0, {15'h0, busy});
		wr_cmd(8'h8C, 1'b1);
		chk("power down", 16'h2, {14'h0, pd, busy});
		rd(3, 32'h00FF_8C8C);
		asel = 3'h3;
		wr_cmd(8'hA5, 1'b1);
		chk("wake", 16'h0, {15'h0, pd});
		rd(3, 32'h00FF_A5A5);
		wrap_up;
	end
endmodule
`default_nettype wire

// >>> testbench/light_sensor_monitor.sv
`default_nettype none
module light_sensor_monitor (
	input wire logic clk, // clock
	input wire logic rst_n, // reset
	input wire logic scl_in, // bus clock
	input wire logic sda_out, // drive value
	input wire logic sda_oe_n, // drive enable
	input wire logic adc_power_down, // converter off
	input wire logic photodiode_dark_sel, // dark diode
	input wire logic conversion_busy, // integrating
	input wire logic [7:0] command_value // command
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	wire conv_cmd = command_value inside {8'h00, 8'h04, 8'h08, 8'h30, 8'h34, 8'h38};
	property p_low;
		sda_out == 1'b0;
	endproperty
	a_low: assert property (p_low) else $error("drive value not low");
	property p_oe;
		$changed(sda_oe_n) |-> !scl_in;
	endproperty
	a_oe: assert property (p_oe) else $error("data moved with clock high");
	property p_cmd;
		$changed(command_value) |-> !scl_in;
	endproperty
	a_cmd: assert property (p_cmd) else $error("command moved off a byte end");
	property p_pwr;
		$changed(command_value) |-> ##[1:4] (adc_power_down == (command_value == 8'h8C));
	endproperty
	a_pwr: assert property (p_pwr) else $error("power state wrong");
	property p_pd_idle;
		adc_power_down |-> !conversion_busy;
	endproperty
	a_pd_idle: assert property (p_pd_idle) else $error("busy while powered down");
	property p_start;
		$changed(command_value) && conv_cmd |-> ##[1:4] conversion_busy;
	endproperty
	a_start: assert property (p_start) else $error("conversion not started");
	property p_clr;
		$changed(command_value) && command_value == 8'h0C |-> ##[1:4] !conversion_busy;
	endproperty
	a_clr: assert property (p_clr) else $error("reset left busy");
	property p_dark;
		($stable(command_value) [*4]) ##0 (conversion_busy && command_value inside {8'h00, 8'h04, 8'h30, 8'h34})
			|-> photodiode_dark_sel == command_value[2];
	endproperty
	a_dark: assert property (p_dark) else $error("wrong diode");
	c_ext: cover property ($changed(command_value) && command_value == 8'h30);
	c_pd: cover property ($rose(adc_power_down));
	c_drv: cover property ($fell(sda_oe_n));
endmodule
bind light_sensor_i2c_command_port light_sensor_monitor u_monitor (.clk, .rst_n, .scl_in, .sda_out, .sda_oe_n,
	.adc_power_down, .photodiode_dark_sel, .conversion_busy, .command_value);
`default_nettype wire
